/* bench/bpk_sink.sv */
// Byte sink standing for the host image buffer
`timescale 1ns/1ps
module bpk_sink
   import bpk_pkg::*;
(
   input wire logic sys_clk,
   input wire logic slow,
   input wire logic byte_valid,
   input wire bpk_byte_s byte_out,
   input wire bpk_colour_e byte_colour,
   output logic byte_ready
);
   logic [12:0] q[$];
   // Capture each accepted byte; ready toggles when slow so the packer must hold its byte
   always @(posedge sys_clk) begin
      if (byte_valid && byte_ready) begin
         q.push_back({byte_colour, byte_out});
      end
      byte_ready <= slow ? !byte_ready : 1'b1;
   end
endmodule : bpk_sink

/* bench/testbench.sv */
// Self-checking bench for the raw pixel row packer
`timescale 1ns/1ps
module testbench
   import bpk_pkg::*;
;
   logic sys_clk, rst_n, pix_valid, pix_eof, pix_ready, byte_valid, byte_ready, row_odd, slow;
   bpk_pix_s pix_in;
   bpk_byte_s byte_out;
   bpk_colour_e byte_colour;
   int fails, checked;
   logic [12:0] e;
   logic [11:0] a, b, ex;
   // Three rows of four pixels: frame A rows 0 and 1, frame B row 0; both ends of the range included
   logic [11:0] tbl [12] = '{12'h123, 12'h456, 12'hfff, 12'h000, 12'habc, 12'hdef,
                             12'h801, 12'h7fe, 12'h0f0, 12'hf0f, 12'h000, 12'hfff};
   bpk_packer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .pix_valid(pix_valid), .pix_in(pix_in),
      .pix_eof(pix_eof), .pix_ready(pix_ready), .byte_valid(byte_valid), .byte_ready(byte_ready),
      .byte_out(byte_out), .byte_colour(byte_colour), .row_odd(row_odd));
   bpk_sink u_sink (.sys_clk(sys_clk), .slow(slow), .byte_valid(byte_valid), .byte_out(byte_out),
      .byte_colour(byte_colour), .byte_ready(byte_ready));
   task summarize;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Present one pixel and hold it until the packer takes it
   task send(input int i);
      int n;
      @(negedge sys_clk);
      slow = (i >= 8);
      pix_valid = 1'b1;
      pix_in = {tbl[i], 1'(i % 8 == 0), 1'(i % 4 == 3)};
      pix_eof = (i == 7 || i == 11);
      n = 0;
      while (pix_ready !== 1'b1 && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      if (pix_ready !== 1'b1) begin
         fails++;
         summarize();
      end
      @(posedge sys_clk);
   endtask : send
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      rst_n = 1'b0;
      pix_valid = 1'b0;
      pix_in = '0;
      pix_eof = 1'b0;
      slow = 1'b0;
      fails = 0;
      checked = 0;
      repeat (16) @(negedge sys_clk);
      chk("ready in reset", 12'(pix_ready), 12'h001);
      chk("valid in reset", 12'(byte_valid), 12'h000);
      rst_n = 1'b1;
      // Pixels back to back; the last row meets a stalling sink
      for (int i = 0; i < 12; i++) begin
         send(i);
      end
      @(negedge sys_clk);
      pix_valid = 1'b0;
      repeat (40) @(negedge sys_clk);
      chk("byte count", 12'(u_sink.q.size()), 12'h012);
      for (int k = 0; k < 18; k++) begin
         e = u_sink.q[k];
         a = tbl[2 * (k / 3)];
         b = tbl[2 * (k / 3) + 1];
         ex = (k % 3 == 0) ? 12'(a[11:4]) : (k % 3 == 1) ? 12'({b[3:0], a[3:0]}) : 12'(b[11:4]);
         chk("byte data", 12'(e[10:3]), ex);
         chk("row start", 12'(e[2]), 12'(k % 6 == 0));
         chk("row end", 12'(e[1]), 12'(k % 6 == 5));
         chk("frame end", 12'(e[0]), 12'(k == 11 || k == 17));
         if (k % 3 != 2)
            chk("colour", 12'(e[12:11]), (k / 6 == 1) ? 12'(BPK_GREEN) : 12'(BPK_BLUE));
         else
            chk("colour", 12'(e[12:11]), (k / 6 == 1) ? 12'(BPK_RED) : 12'(BPK_GREEN));
      end
      chk("parity after row", 12'(row_odd), 12'h001);
      // Reset once all rows have drained, then one fresh pair must start an even row
      rst_n = 1'b0;
      @(negedge sys_clk);
      chk("ready in reset", 12'(pix_ready), 12'h001);
      chk("valid in reset", 12'(byte_valid), 12'h000);
      chk("parity in reset", 12'(row_odd), 12'h000);
      rst_n = 1'b1;
      send(0);
      send(1);
      @(negedge sys_clk);
      pix_valid = 1'b0;
      repeat (10) @(negedge sys_clk);
      chk("byte count", 12'(u_sink.q.size()), 12'h015);
      e = u_sink.q[18];
      chk("byte data", 12'(e[10:3]), 12'(tbl[0][11:4]));
      chk("row start", 12'(e[2]), 12'h001);
      chk("colour", 12'(e[12:11]), 12'(BPK_BLUE));
      summarize();
   end
endmodule : testbench

/* rtl/bpk_map.svh */
// Constants of the raw 12-bit colour-filter row packer
// Operation
// - Every output pixel carries exactly twelve bits of sample data.
// - Pixels pair up consecutively; each pair leaves as exactly three bytes, no padding.
// - Samples pass unmodified; no interpolation or colour processing.
// - First byte of a group holds first pixel bits eleven to four.
// - Second byte: first pixel bits three-zero low, second pixel bits three-zero high.
// - Third byte of a group holds second pixel bits eleven to four.
// - Even rows: blue at even positions, green at odd, blue first.
// - Odd rows: green at even positions, red at odd, green first.
// - Packing restarts each row; last row byte is final pixel upper bits.
// - Samples are unsigned binary, zero to 4095, proportional to signal level.
`ifndef BPK_MAP_SVH
`define BPK_MAP_SVH
`define BPK_PIX_W 12
`define BPK_HI_MSB 11
`define BPK_HI_LSB 4
`define BPK_LO_MSB 3
`define BPK_LO_LSB 0
`define BPK_PIX_MAX 12'hfff
`define BPK_PH_B0 2'h0
`define BPK_PH_B1 2'h1
`define BPK_PH_B2 2'h2
`endif

/* rtl/bpk_packer.sv */
// Packs pairs of 12-bit raw pixels into three bytes per pair
`timescale 1ns/1ps
`include "bpk_map.svh"
module bpk_packer
   import bpk_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic pix_valid,
   input wire bpk_pix_s pix_in,
   input wire logic pix_eof,
   output logic pix_ready,
   output logic byte_valid,
   input wire logic byte_ready,
   output bpk_byte_s byte_out,
   output bpk_colour_e byte_colour,
   output logic row_odd
);
   typedef struct packed {
      bpk_state_e st;
      logic [1:0] phase;
      logic [11:0] first;
      logic [11:0] second;
      logic have_first;
      logic pair_eol;
      logic pair_eof;
      logic row_odd;
      logic at_row_start;
      logic pix_ready;
      logic byte_valid;
      bpk_byte_s byte_out;
      bpk_colour_e colour;
   } bpk_state_s;

   // The whole packer state lives in one register so that the outputs
   // are plain flip-flop copies with no logic behind the pins.
   // Fields:
   //   st and phase walk the three-byte group; phase only moves in SEND.
   //   first and second hold the two samples of the pair, bit for bit.
   //   have_first tells whether the pair is half filled.
   //   pair_eol and pair_eof copy the row and frame marks of the pair.
   //   row_odd is the parity of the row now being packed.
   //   at_row_start marks that the next first byte opens a row.
   // Limitation: a row with an odd pixel count would leave half a pair
   // behind and shift every later pair; the source must keep rows even.
   // Trade-off: the packer takes no pixel while a pair drains, so it
   // needs five clock cycles per two pixels and no buffer at all.

   bpk_state_s s_q;
   bpk_state_s s_d;
   logic byte_take;
   logic pix_take;

   assign byte_take = s_q.byte_valid & byte_ready;
   assign pix_take = pix_valid & s_q.pix_ready;

   // Next state: collect two pixels, then stream three bytes
   always_comb begin
      s_d = s_q;
      if (byte_take) begin
         s_d.byte_valid = 1'b0;
      end
      case (s_q.st)
         BPK_IDLE: begin
            if (pix_take) begin
               if (pix_in.sof) begin
                  s_d.row_odd = 1'b0;
                  s_d.at_row_start = 1'b1;
               end
               if (!s_q.have_first) begin
                  s_d.first = pix_in.data;
                  s_d.have_first = 1'b1;
               end else begin
                  // Pair complete; stop taking pixels until it drains
                  s_d.second = pix_in.data;
                  s_d.have_first = 1'b0;
                  s_d.pair_eol = pix_in.eol;
                  s_d.pair_eof = pix_eof;
                  s_d.pix_ready = 1'b0;
                  s_d.st = BPK_SEND;
                  s_d.phase = `BPK_PH_B0;
               end
            end
         end
         BPK_SEND: begin
            if (!s_q.byte_valid || byte_take) begin
               s_d.byte_valid = 1'b1;
               s_d.byte_out.sol = 1'b0;
               s_d.byte_out.eol = 1'b0;
               s_d.byte_out.eof = 1'b0;
               case (s_q.phase)
                  `BPK_PH_B0: begin
                     s_d.byte_out.data = s_q.first[`BPK_HI_MSB:`BPK_HI_LSB];
                     s_d.byte_out.sol = s_q.at_row_start;
                     s_d.colour = s_q.row_odd ? BPK_GREEN : BPK_BLUE;
                     s_d.at_row_start = 1'b0;
                     s_d.phase = `BPK_PH_B1;
                  end
                  `BPK_PH_B1: begin
                     s_d.byte_out.data = {s_q.second[`BPK_LO_MSB:`BPK_LO_LSB],
                                          s_q.first[`BPK_LO_MSB:`BPK_LO_LSB]};
                     s_d.colour = s_q.row_odd ? BPK_GREEN : BPK_BLUE;
                     s_d.phase = `BPK_PH_B2;
                  end
                  default: begin
                     s_d.byte_out.data = s_q.second[`BPK_HI_MSB:`BPK_HI_LSB];
                     s_d.colour = s_q.row_odd ? BPK_RED : BPK_GREEN;
                     s_d.byte_out.eol = s_q.pair_eol;
                     s_d.byte_out.eof = s_q.pair_eof;
                     if (s_q.pair_eol) begin
                        // Next row flips parity and packing starts over
                        s_d.row_odd = ~s_q.row_odd;
                        s_d.at_row_start = 1'b1;
                     end
                     s_d.phase = `BPK_PH_B0;
                     s_d.pix_ready = 1'b1;
                     s_d.st = BPK_IDLE;
                  end
               endcase
            end
         end
         default: begin
            s_d.st = BPK_IDLE;
            s_d.pix_ready = 1'b1;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.pix_ready <= 1'b1;
         s_q.at_row_start <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign pix_ready = s_q.pix_ready;
   assign byte_valid = s_q.byte_valid;
   assign byte_out = s_q.byte_out;
   assign byte_colour = s_q.colour;
   assign row_odd = s_q.row_odd;

   // Checks on the pixel input, the pair registers and the byte stream
   // A byte slot is loaded whenever SEND finds the output empty or drained
   logic byte_load;
   assign byte_load = (s_q.st == BPK_SEND) & (!s_q.byte_valid | byte_take);

   // The checks below but a_pair_three_bytes, which reads s_d, watch the registered state directly, so a fault in
   // the next-state logic shows one cycle after the edge that loaded it.
   // Byte contents are compared against the pair as it stood at the load.
   // Colour checks follow the row parity that was current at the load,
   // because the parity flips on the same edge as the row's last byte.

   a_pair_three_bytes: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == BPK_IDLE && s_d.st == BPK_SEND) |-> ##1 !pix_ready [*3])
      else $error("pixel taken while a pair was still being sent");
   a_byte0_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == BPK_SEND && s_q.phase == `BPK_PH_B0 && (!byte_valid || byte_take))
      |=> byte_out.data == $past(s_q.first[`BPK_HI_MSB:`BPK_HI_LSB]))
      else $error("first byte not upper bits of first pixel");
   a_byte1_nibbles: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == BPK_SEND && s_q.phase == `BPK_PH_B1 && (!byte_valid || byte_take))
      |=> byte_out.data == {$past(s_q.second[`BPK_LO_MSB:`BPK_LO_LSB]), $past(s_q.first[`BPK_LO_MSB:`BPK_LO_LSB])})
      else $error("middle byte nibbles misplaced");
   a_byte2_upper: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == BPK_SEND && s_q.phase == `BPK_PH_B2 && (!byte_valid || byte_take))
      |=> byte_out.data == $past(s_q.second[`BPK_HI_MSB:`BPK_HI_LSB]))
      else $error("third byte not upper bits of second pixel");
   a_even_colours: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_valid && !row_odd && !byte_out.eol) |-> byte_colour != BPK_RED)
      else $error("red sample on an even row");
   a_odd_colours: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_valid && row_odd && !byte_out.eol) |-> byte_colour != BPK_BLUE)
      else $error("blue sample on an odd row");
   a_row_flip: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_load && s_q.phase == `BPK_PH_B2 && s_q.pair_eol) |=> row_odd != $past(row_odd))
      else $error("row parity did not advance after end of row");
   a_eol_last: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_valid && byte_out.eol) |-> byte_colour != BPK_BLUE)
      else $error("row end not on second pixel upper byte");
   a_sample_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == BPK_SEND) |-> s_q.first <= `BPK_PIX_MAX && s_q.second <= `BPK_PIX_MAX)
      else $error("sample out of twelve-bit range");
   a_row_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pix_take && pix_in.sof) |=> !row_odd)
      else $error("frame start did not return to even row");

   // A stalled byte must not change under the sink
   a_byte_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_valid && !byte_ready) |=> byte_valid && $stable(byte_out))
      else $error("byte changed while stalled");

   // The colour tag stays with its byte through a stall
   a_colour_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_valid && !byte_ready) |=> $stable(byte_colour))
      else $error("colour changed while stalled");

   // Collecting pixels means the input is open
   a_ready_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == BPK_IDLE) |-> pix_ready)
      else $error("input closed while collecting");

   // Draining a pair keeps the input shut
   a_shut_send: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == BPK_SEND) |-> !pix_ready)
      else $error("input open while a pair drains");

   // The first sample of a pair is stored untouched
   a_first_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pix_take && s_q.st == BPK_IDLE && !s_q.have_first) |=> s_q.first == $past(pix_in.data))
      else $error("first sample altered on capture");

   // The second sample of a pair is stored untouched
   a_second_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (pix_take && s_q.st == BPK_IDLE && s_q.have_first) |=> s_q.second == $past(pix_in.data))
      else $error("second sample altered on capture");

   // Row start only ever marks the first byte of a group
   a_sol_first_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_valid && byte_out.sol) |-> s_q.st == BPK_SEND && s_q.phase == `BPK_PH_B1)
      else $error("row start on a later byte");

   // Row end only ever marks the third byte of a group
   a_eol_third_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_valid && byte_out.eol) |-> s_q.phase == `BPK_PH_B0)
      else $error("row end on an earlier byte");

   // Frame end rides on the third byte as well
   a_eof_third_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_valid && byte_out.eof) |-> s_q.phase == `BPK_PH_B0)
      else $error("frame end on an earlier byte");

   // First byte colour: blue on even rows, green on odd rows
   a_b0_colour: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_load && s_q.phase == `BPK_PH_B0) |=> byte_colour == ($past(row_odd) ? BPK_GREEN : BPK_BLUE))
      else $error("first byte colour wrong for row");

   // Middle byte reports the first pixel's colour
   a_b1_colour: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_load && s_q.phase == `BPK_PH_B1) |=> byte_colour == ($past(row_odd) ? BPK_GREEN : BPK_BLUE))
      else $error("middle byte colour wrong for row");

   // Third byte colour: green on even rows, red on odd rows
   a_b2_colour: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_load && s_q.phase == `BPK_PH_B2) |=> byte_colour == ($past(row_odd) ? BPK_RED : BPK_GREEN))
      else $error("third byte colour wrong for row");

   // A row end arms the row start of the next group
   a_sol_rearm: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_load && s_q.phase == `BPK_PH_B2 && s_q.pair_eol) |=> s_q.at_row_start)
      else $error("row start not armed after row end");

   // Inside a row no group may claim a row start
   a_no_mid_sol: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_load && s_q.phase == `BPK_PH_B2 && !s_q.pair_eol) |=> !s_q.at_row_start)
      else $error("row start armed inside a row");

   // Only three byte phases exist
   a_phase_legal: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_q.phase <= `BPK_PH_B2)
      else $error("byte phase out of range");

   // No half pair may be pending while a pair drains
   a_no_half_send: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == BPK_SEND) |-> !s_q.have_first)
      else $error("half pair left over while sending");

   // A taken byte in SEND is followed at once by the next one
   a_byte_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_take && s_q.st == BPK_SEND) |=> byte_valid)
      else $error("gap inside a byte group");

   // Loading the third byte reopens the input
   a_ready_reopen: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (byte_load && s_q.phase == `BPK_PH_B2) |=> pix_ready && s_q.st == BPK_IDLE)
      else $error("input not reopened after third byte");

   // Outside a row end the parity stays put unless a frame starts
   a_parity_steady: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !(byte_load && s_q.phase == `BPK_PH_B2 && s_q.pair_eol) && !(pix_take && pix_in.sof)
      |=> $stable(row_odd))
      else $error("row parity moved inside a row");
endmodule : bpk_packer

/* rtl/bpk_pkg.sv */
// Types of the raw 12-bit colour-filter row packer
package bpk_pkg;
   typedef enum logic [1:0] {
      BPK_BLUE = 2'b00,
      BPK_GREEN = 2'b01,
      BPK_RED = 2'b10
   } bpk_colour_e;
   typedef enum logic [1:0] {
      BPK_IDLE = 2'b00,
      BPK_SEND = 2'b01
   } bpk_state_e;
   typedef struct packed {
      logic [11:0] data;
      logic sof;
      logic eol;
   } bpk_pix_s;
   typedef struct packed {
      logic [7:0] data;
      logic sol;
      logic eol;
      logic eof;
   } bpk_byte_s;
endpackage : bpk_pkg
